/* design/cfg_bank_pkg.sv */
package cfg_bank_pkg;

  // bus-visible words (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // control word fields
  localparam int CTRL_CONFIG_STATE = 0;
  localparam int CTRL_EPP_ENABLE = 1;
  localparam int CTRL_ECP_MODE = 2;
  localparam int CTRL_POWER_GOOD_SEL = 3;
  localparam int CTRL_WIDTH = 4;

  // configuration register indexes
  localparam logic [7:0] IDX_DRIVE_STATUS_OVERRIDE = 8'h17;
  localparam logic [7:0] IDX_GAME_SELECT_BASE = 8'h1E;
  localparam logic [7:0] IDX_DRIVE_TYPE_MAP = 8'h1F;
  localparam logic [7:0] IDX_FLOPPY_BASE = 8'h20;
  localparam logic [7:0] IDX_PARALLEL_BASE = 8'h23;
  localparam logic [7:0] IDX_SERIAL_ONE_BASE = 8'h24;
  localparam logic [7:0] IDX_SERIAL_TWO_BASE = 8'h25;
  localparam logic [7:0] IDX_DMA_SELECT = 8'h26;
  localparam logic [7:0] IDX_IRQ_SELECT = 8'h27;

  // values after reset
  localparam logic [7:0] RST_DRIVE_STATUS_OVERRIDE = 8'h03;
  localparam logic [7:0] RST_GAME_SELECT_BASE = 8'h80;
  localparam logic [7:0] RST_DRIVE_TYPE_MAP = 8'h00;
  localparam logic [7:0] RST_FLOPPY_BASE = 8'h3C;
  localparam logic [7:0] RST_PARALLEL_BASE = 8'h00;
  localparam logic [7:0] RST_SERIAL_BASE = 8'h00;
  localparam logic [7:0] RST_ROUTE_SELECT = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;

  // override bit positions
  localparam int OVR_CHANGE_0 = 0;
  localparam int OVR_CHANGE_1 = 1;
  localparam int OVR_PROTECT_0 = 2;
  localparam int OVR_PROTECT_1 = 3;

  // game select decode modes
  localparam logic [1:0] GAME_OFF = 2'h0;
  localparam logic [1:0] GAME_ONE_BYTE = 2'h1;
  localparam logic [1:0] GAME_EIGHT = 2'h2;
  localparam logic [1:0] GAME_SIXTEEN = 2'h3;
  localparam logic [3:0] GAME_ONE_BYTE_NIBBLE = 4'h1;

  // route lines: dma A..C, irq A..H (code 7 reserved)
  localparam int DMA_LINES = 3;
  localparam int IRQ_LINES = 8;
  localparam logic [3:0] IRQ_RESERVED_CODE = 4'h7;
  localparam logic [3:0] NO_RESERVED_CODE = 4'hF;

  typedef struct packed {
    logic [7:0] override;
    logic [7:0] game_base;
    logic [7:0] type_map;
    logic [7:0] floppy_base;
    logic [7:0] parallel_base;
    logic [7:0] serial_one_base;
    logic [7:0] serial_two_base;
    logic [7:0] dma_select;
    logic [7:0] irq_select;
  } bank_regs_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_e;

endpackage

/* design/io_base_decoder.sv */
`timescale 1ns/1ps
module io_base_decoder
  import cfg_bank_pkg::*;
(
  input wire logic [9:0] base_addr,
  input wire logic [9:0] care_mask,
  input wire logic enable,
  input wire logic a10_free,
  input wire logic [10:0] host_addr,
  input wire logic chip_select_n,
  input wire logic io_valid,
  output logic hit
);

  // every compared address bit must equal the programmed base
  always_comb
  begin
    hit = io_valid && !chip_select_n && enable
      && (a10_free || !host_addr[10])
      && (((host_addr[9:0] ^ base_addr) & care_mask) == 10'h000);
  end

endmodule // io_base_decoder

/* design/route_select.sv */
`timescale 1ns/1ps
module route_select
  import cfg_bank_pkg::*;
#(
  parameter int LINES = 8,
  parameter logic [3:0] RESERVED = 4'hF
)
(
  input wire logic [3:0] code,
  input wire logic request,
  output logic [LINES-1:0] line_out,
  output logic [LINES-1:0] line_oe
);

  // code n selects line n-1; zero, reserved and out-of-range drive none
  genvar i;
  generate
    for (i = 0; i < LINES; i++)
    begin : g_line
      always_comb
      begin
        line_oe[i] = (code == 4'(i + 1)) && (code != RESERVED);
        line_out[i] = line_oe[i] && request;
      end
    end
  endgenerate

endmodule // route_select

/* design/superio_resource_config_bank.sv */
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module superio_resource_config_bank
  import cfg_bank_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [10:0] HOST_ADDR,
  input wire logic CHIP_SELECT_N,
  input wire logic HOST_IO_VALID,
  input wire logic DISK_CHANGED_IN_N,
  input wire logic WRITE_PROTECT_IN_N,
  input wire logic STEP_PULSE_N,
  input wire logic DRIVE_SELECT_0_N,
  input wire logic DRIVE_SELECT_1_N,
  input wire logic [1:0] DRIVE_NUMBER,
  input wire logic DENSITY_SELECT,
  input wire logic RATE0,
  input wire logic RATE1,
  input wire logic FLOPPY_DMA_REQ,
  input wire logic PARALLEL_DMA_REQ,
  input wire logic FLOPPY_IRQ,
  input wire logic PARALLEL_IRQ,
  output logic FLOPPY_DISK_CHANGED_N,
  output logic FLOPPY_WRITE_PROTECT_N,
  output logic DENSITY_OUT_0,
  output logic DENSITY_OUT_1,
  output logic GAME_PORT_SELECT,
  output logic FLOPPY_SELECT,
  output logic PARALLEL_SELECT,
  output logic SERIAL_ONE_SELECT,
  output logic SERIAL_TWO_SELECT,
  output logic [DMA_LINES-1:0] DMA_REQ_OUT,
  output logic [DMA_LINES-1:0] DMA_REQ_OE,
  output logic [IRQ_LINES-1:0] IRQ_OUT,
  output logic [IRQ_LINES-1:0] IRQ_OE
);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  bus_state_e bus_state_reg;
  logic write_pend_reg;
  logic [7:0] addr_reg;
  logic [CTRL_WIDTH-1:0] ctrl_reg;
  logic [7:0] index_reg;
  bank_regs_s bank_reg;
  logic addr_phase;
  logic wr_data;
  logic wr_cfg;
  logic [7:0] cfg_read;
  logic [31:0] read_word;
  logic changed_eff;
  logic protect_eff;
  logic [1:0] drive_type;
  logic game_hit;
  logic game_low_ok;
  logic floppy_hit;
  logic parallel_hit;
  logic serial_one_hit;
  logic serial_two_hit;
  logic [9:0] parallel_mask;
  logic [DMA_LINES-1:0] dma_fl_out;
  logic [DMA_LINES-1:0] dma_fl_oe;
  logic [DMA_LINES-1:0] dma_pp_out;
  logic [DMA_LINES-1:0] dma_pp_oe;
  logic [IRQ_LINES-1:0] irq_fl_out;
  logic [IRQ_LINES-1:0] irq_fl_oe;
  logic [IRQ_LINES-1:0] irq_pp_out;
  logic [IRQ_LINES-1:0] irq_pp_oe;

  // reset release through two flops
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // bus slave: writes complete with no wait, reads with one wait state
  assign addr_phase = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state_reg <= BUS_IDLE;
      write_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h0000_0000;
      HRESP <= 1'b0;
    end
    else
    begin
      HRESP <= 1'b0;
      case (bus_state_reg)
        BUS_IDLE:
        begin
          write_pend_reg <= addr_phase && HWRITE;
          if (addr_phase)
            addr_reg <= {HADDR[7:2], 2'b00};
          if (addr_phase && !HWRITE)
          begin
            bus_state_reg <= BUS_READ;
            HREADYOUT <= 1'b0;
          end
        end
        BUS_READ:
        begin
          write_pend_reg <= 1'b0;
          HRDATA <= read_word;
          HREADYOUT <= 1'b1;
          bus_state_reg <= BUS_IDLE;
        end
        default:
        begin
          bus_state_reg <= BUS_IDLE;
          write_pend_reg <= 1'b0;
          HREADYOUT <= 1'b1;
        end
      endcase
    end
  end

  assign wr_data = write_pend_reg;
  assign wr_cfg = wr_data && (addr_reg == ADDR_DATA)
    && ctrl_reg[CTRL_CONFIG_STATE];

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= '0;
    else if (wr_data && (addr_reg == ADDR_CTRL))
      ctrl_reg <= HWDATA[CTRL_WIDTH-1:0];
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      index_reg <= RST_INDEX;
    else if (wr_data && (addr_reg == ADDR_INDEX)
      && ctrl_reg[CTRL_CONFIG_STATE])
      index_reg <= HWDATA[7:0];
  end

  // forced change bits: software may only set, hardware clears
  genvar d;
  generate
    for (d = 0; d < 2; d++)
    begin : g_change
      logic clear_cond;
      assign clear_cond = STEP_PULSE_N
        && ((d == 0) ? DRIVE_SELECT_0_N : DRIVE_SELECT_1_N);
      always_ff @(posedge SYS_CLK or negedge rst_n)
      begin
        if (!rst_n)
          bank_reg.override[d] <= RST_DRIVE_STATUS_OVERRIDE[d];
        else if (wr_cfg && (index_reg == IDX_DRIVE_STATUS_OVERRIDE)
          && HWDATA[d])
          bank_reg.override[d] <= 1'b1;
        else if (clear_cond)
          bank_reg.override[d] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      bank_reg.override[7:2] <= {4'h0,
        RST_DRIVE_STATUS_OVERRIDE[OVR_PROTECT_1:OVR_PROTECT_0]};
    else if (wr_cfg && (index_reg == IDX_DRIVE_STATUS_OVERRIDE))
      bank_reg.override[7:2] <=
        {4'h0, HWDATA[OVR_PROTECT_1:OVR_PROTECT_0]};
  end

  // resource registers; reserved indexes fall through untouched
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_reg.game_base <= RST_GAME_SELECT_BASE;
      bank_reg.type_map <= RST_DRIVE_TYPE_MAP;
      bank_reg.floppy_base <= RST_FLOPPY_BASE;
      bank_reg.parallel_base <= RST_PARALLEL_BASE;
      bank_reg.serial_one_base <= RST_SERIAL_BASE;
      bank_reg.serial_two_base <= RST_SERIAL_BASE;
      bank_reg.dma_select <= RST_ROUTE_SELECT;
      bank_reg.irq_select <= RST_ROUTE_SELECT;
    end
    else if (wr_cfg)
    begin
      case (index_reg)
        IDX_GAME_SELECT_BASE:
          bank_reg.game_base <= HWDATA[7:0];
        IDX_DRIVE_TYPE_MAP:
          bank_reg.type_map <= HWDATA[7:0];
        IDX_FLOPPY_BASE:
          bank_reg.floppy_base <= {HWDATA[7:2], 2'b00};
        IDX_PARALLEL_BASE:
          bank_reg.parallel_base <= HWDATA[7:0];
        IDX_SERIAL_ONE_BASE:
          bank_reg.serial_one_base <= {HWDATA[7:1], 1'b0};
        IDX_SERIAL_TWO_BASE:
          bank_reg.serial_two_base <= {HWDATA[7:1], 1'b0};
        IDX_DMA_SELECT:
          bank_reg.dma_select <= HWDATA[7:0];
        IDX_IRQ_SELECT:
          bank_reg.irq_select <= HWDATA[7:0];
        default:
          bank_reg.irq_select <= bank_reg.irq_select;
      endcase
    end
  end

  // configuration data read through the index
  always_comb
  begin
    case (index_reg)
      IDX_DRIVE_STATUS_OVERRIDE: cfg_read = bank_reg.override;
      IDX_GAME_SELECT_BASE: cfg_read = bank_reg.game_base;
      IDX_DRIVE_TYPE_MAP: cfg_read = bank_reg.type_map;
      IDX_FLOPPY_BASE: cfg_read = bank_reg.floppy_base;
      IDX_PARALLEL_BASE: cfg_read = bank_reg.parallel_base;
      IDX_SERIAL_ONE_BASE: cfg_read = bank_reg.serial_one_base;
      IDX_SERIAL_TWO_BASE: cfg_read = bank_reg.serial_two_base;
      IDX_DMA_SELECT: cfg_read = bank_reg.dma_select;
      IDX_IRQ_SELECT: cfg_read = bank_reg.irq_select;
      default: cfg_read = 8'h00;
    endcase
  end

  always_comb
  begin
    case (addr_reg)
      ADDR_CTRL: read_word = {28'h0000000, ctrl_reg};
      ADDR_INDEX: read_word = {24'h000000, index_reg};
      ADDR_DATA: read_word = ctrl_reg[CTRL_CONFIG_STATE] ?
        {24'h000000, cfg_read} : 32'h0000_0000;
      ADDR_STATUS: read_word = {24'h000000, changed_eff, protect_eff,
        GAME_PORT_SELECT, FLOPPY_SELECT, PARALLEL_SELECT,
        SERIAL_ONE_SELECT, SERIAL_TWO_SELECT, 1'b0};
      default: read_word = 32'h0000_0000;
    endcase
  end

  // drive status seen by the floppy controller
  always_comb
  begin
    changed_eff = (DRIVE_SELECT_0_N && bank_reg.override[OVR_CHANGE_0])
      || (DRIVE_SELECT_1_N && bank_reg.override[OVR_CHANGE_1])
      || DISK_CHANGED_IN_N;
    protect_eff = (DRIVE_SELECT_0_N && bank_reg.override[OVR_PROTECT_0])
      || (DRIVE_SELECT_1_N && bank_reg.override[OVR_PROTECT_1])
      || WRITE_PROTECT_IN_N;
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      FLOPPY_DISK_CHANGED_N <= 1'b1;
      FLOPPY_WRITE_PROTECT_N <= 1'b1;
    end
    else
    begin
      FLOPPY_DISK_CHANGED_N <= changed_eff;
      FLOPPY_WRITE_PROTECT_N <= protect_eff;
    end
  end

  // density outputs by drive type: type_bit_a high, type_bit_b low
  assign drive_type = bank_reg.type_map[2*DRIVE_NUMBER +: 2];

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      DENSITY_OUT_0 <= 1'b0;
      DENSITY_OUT_1 <= 1'b0;
    end
    else
    begin
      case (drive_type)
        2'h0:
        begin
          DENSITY_OUT_0 <= DENSITY_SELECT;
          DENSITY_OUT_1 <= RATE0;
        end
        2'h1:
        begin
          DENSITY_OUT_0 <= RATE1;
          DENSITY_OUT_1 <= RATE0;
        end
        2'h2:
        begin
          DENSITY_OUT_0 <= !DENSITY_SELECT;
          DENSITY_OUT_1 <= RATE0;
        end
        default:
        begin
          DENSITY_OUT_0 <= RATE0;
          DENSITY_OUT_1 <= RATE1;
        end
      endcase
    end
  end

  // game select low nibble qualifier
  always_comb
  begin
    case (bank_reg.game_base[1:0])
      GAME_ONE_BYTE: game_low_ok = HOST_ADDR[3:0] == GAME_ONE_BYTE_NIBBLE;
      GAME_EIGHT: game_low_ok = !HOST_ADDR[3];
      GAME_SIXTEEN: game_low_ok = 1'b1;
      default: game_low_ok = 1'b0;
    endcase
  end

  io_base_decoder u_game_dec (
    .base_addr({bank_reg.game_base[7:2], 4'h0}),
    .care_mask(10'h3F0),
    .enable(game_low_ok && !ctrl_reg[CTRL_POWER_GOOD_SEL]),
    .a10_free(1'b0),
    .host_addr(HOST_ADDR),
    .chip_select_n(CHIP_SELECT_N),
    .io_valid(HOST_IO_VALID),
    .hit(game_hit)
  );

  io_base_decoder u_floppy_dec (
    .base_addr({bank_reg.floppy_base[7:2], 4'h0}),
    .care_mask(10'h3F8),
    .enable(bank_reg.floppy_base[7:6] != 2'h0),
    .a10_free(1'b0),
    .host_addr(HOST_ADDR),
    .chip_select_n(CHIP_SELECT_N),
    .io_valid(HOST_IO_VALID),
    .hit(floppy_hit)
  );

  assign parallel_mask = ctrl_reg[CTRL_EPP_ENABLE] ? 10'h3F8 : 10'h3FC;

  io_base_decoder u_parallel_dec (
    .base_addr({bank_reg.parallel_base, 2'h0}),
    .care_mask(parallel_mask),
    .enable(bank_reg.parallel_base[7:6] != 2'h0),
    .a10_free(ctrl_reg[CTRL_ECP_MODE]),
    .host_addr(HOST_ADDR),
    .chip_select_n(CHIP_SELECT_N),
    .io_valid(HOST_IO_VALID),
    .hit(parallel_hit)
  );

  io_base_decoder u_serial_one_dec (
    .base_addr({bank_reg.serial_one_base[7:1], 3'h0}),
    .care_mask(10'h3F8),
    .enable(bank_reg.serial_one_base[7:6] != 2'h0),
    .a10_free(1'b0),
    .host_addr(HOST_ADDR),
    .chip_select_n(CHIP_SELECT_N),
    .io_valid(HOST_IO_VALID),
    .hit(serial_one_hit)
  );

  io_base_decoder u_serial_two_dec (
    .base_addr({bank_reg.serial_two_base[7:1], 3'h0}),
    .care_mask(10'h3F8),
    .enable(bank_reg.serial_two_base[7:6] != 2'h0),
    .a10_free(1'b0),
    .host_addr(HOST_ADDR),
    .chip_select_n(CHIP_SELECT_N),
    .io_valid(HOST_IO_VALID),
    .hit(serial_two_hit)
  );

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      GAME_PORT_SELECT <= 1'b0;
      FLOPPY_SELECT <= 1'b0;
      PARALLEL_SELECT <= 1'b0;
      SERIAL_ONE_SELECT <= 1'b0;
      SERIAL_TWO_SELECT <= 1'b0;
    end
    else
    begin
      GAME_PORT_SELECT <= game_hit;
      FLOPPY_SELECT <= floppy_hit;
      PARALLEL_SELECT <= parallel_hit;
      SERIAL_ONE_SELECT <= serial_one_hit;
      SERIAL_TWO_SELECT <= serial_two_hit;
    end
  end

  // request and interrupt routing, upper nibble floppy, lower parallel
  route_select #(.LINES(DMA_LINES), .RESERVED(NO_RESERVED_CODE))
    u_dma_floppy (
    .code(bank_reg.dma_select[7:4]),
    .request(FLOPPY_DMA_REQ),
    .line_out(dma_fl_out),
    .line_oe(dma_fl_oe)
  );

  route_select #(.LINES(DMA_LINES), .RESERVED(NO_RESERVED_CODE))
    u_dma_parallel (
    .code(bank_reg.dma_select[3:0]),
    .request(PARALLEL_DMA_REQ),
    .line_out(dma_pp_out),
    .line_oe(dma_pp_oe)
  );

  route_select #(.LINES(IRQ_LINES), .RESERVED(IRQ_RESERVED_CODE))
    u_irq_floppy (
    .code(bank_reg.irq_select[7:4]),
    .request(FLOPPY_IRQ),
    .line_out(irq_fl_out),
    .line_oe(irq_fl_oe)
  );

  route_select #(.LINES(IRQ_LINES), .RESERVED(IRQ_RESERVED_CODE))
    u_irq_parallel (
    .code(bank_reg.irq_select[3:0]),
    .request(PARALLEL_IRQ),
    .line_out(irq_pp_out),
    .line_oe(irq_pp_oe)
  );

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      DMA_REQ_OUT <= '0;
      DMA_REQ_OE <= '0;
      IRQ_OUT <= '0;
      IRQ_OE <= '0;
    end
    else
    begin
      DMA_REQ_OUT <= dma_fl_out | dma_pp_out;
      DMA_REQ_OE <= dma_fl_oe | dma_pp_oe;
      IRQ_OUT <= irq_fl_out | irq_pp_out;
      IRQ_OE <= irq_fl_oe | irq_pp_oe;
    end
  end

endmodule // superio_resource_config_bank

/* testbench/cfg_bank_assertions.sv */
`timescale 1ns/1ps
module cfg_bank_checker
  import cfg_bank_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [10:0] HOST_ADDR,
  input wire logic CHIP_SELECT_N,
  input wire logic HOST_IO_VALID,
  input wire logic DISK_CHANGED_IN_N,
  input wire logic WRITE_PROTECT_IN_N,
  input wire logic FLOPPY_DISK_CHANGED_N,
  input wire logic FLOPPY_WRITE_PROTECT_N,
  input wire logic GAME_PORT_SELECT,
  input wire logic FLOPPY_SELECT,
  input wire logic PARALLEL_SELECT,
  input wire logic SERIAL_ONE_SELECT,
  input wire logic SERIAL_TWO_SELECT,
  input wire logic [DMA_LINES-1:0] DMA_REQ_OUT,
  input wire logic [DMA_LINES-1:0] DMA_REQ_OE,
  input wire logic [IRQ_LINES-1:0] IRQ_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  wire qual = !CHIP_SELECT_N && HOST_IO_VALID;
  sequence rd_taken;
    HSEL && HTRANS[1] && !HWRITE && HREADY;
  endsequence
  sequence one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  read_wait_a: assert property (rd_taken |=> one_wait)
    else $error("read wait state wrong");
  write_nowait_a: assert property (HSEL && HTRANS[1] && HWRITE && HREADY
    |=> HREADYOUT) else $error("write was stalled");
  change_pin_a: assert property ($past(DISK_CHANGED_IN_N)
    |-> FLOPPY_DISK_CHANGED_N) else $error("disk change pin term lost");
  protect_pin_a: assert property ($past(WRITE_PROTECT_IN_N)
    |-> FLOPPY_WRITE_PROTECT_N) else $error("protect pin term lost");
  game_qual_a: assert property (GAME_PORT_SELECT
    |-> $past(qual && !HOST_ADDR[10])) else $error("game select unqualified");
  floppy_qual_a: assert property (FLOPPY_SELECT
    |-> $past(qual && !HOST_ADDR[10] && !HOST_ADDR[3]))
    else $error("floppy select unqualified");
  serial_qual_a: assert property (SERIAL_ONE_SELECT || SERIAL_TWO_SELECT
    |-> $past(qual && !HOST_ADDR[10]))
    else $error("serial select unqualified");
  parallel_qual_a: assert property (PARALLEL_SELECT |-> $past(qual))
    else $error("parallel select unqualified");
  dma_tristate_a: assert property ((DMA_REQ_OUT & ~DMA_REQ_OE) == '0)
    else $error("undriven request line carries value");
  irq_unused_a: assert property (!IRQ_OE[6])
    else $error("unused interrupt line driven");
endmodule // cfg_bank_checker

bind superio_resource_config_bank cfg_bank_checker i_chk (
  .SYS_CLK, .RSTN, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT,
  .HOST_ADDR, .CHIP_SELECT_N, .HOST_IO_VALID, .DISK_CHANGED_IN_N,
  .WRITE_PROTECT_IN_N, .FLOPPY_DISK_CHANGED_N, .FLOPPY_WRITE_PROTECT_N,
  .GAME_PORT_SELECT, .FLOPPY_SELECT, .PARALLEL_SELECT, .SERIAL_ONE_SELECT,
  .SERIAL_TWO_SELECT, .DMA_REQ_OUT, .DMA_REQ_OE, .IRQ_OE
);

/* testbench/isa_host_model.sv */
`timescale 1ns/1ps
module isa_host_model
(
  input wire logic clk,
  output logic [10:0] host_addr,
  output logic cs_n,
  output logic io_valid
);
  initial
  begin
    host_addr = 11'h7FF;
    cs_n = 1'b1;
    io_valid = 1'b0;
  end
  // one i/o cycle; released address shows the inverse, not the old value
  task automatic cycle(input logic [10:0] a, input logic c);
    @(posedge clk);
    host_addr <= a;
    cs_n <= c;
    io_valid <= 1'b1;
    @(posedge clk);
    host_addr <= ~a;
    cs_n <= 1'b1;
    io_valid <= 1'b0;
  endtask
endmodule // isa_host_model

/* testbench/test_superio_resource_config_bank.sv */
`timescale 1ns/1ps
module test_superio_resource_config_bank
  import cfg_bank_pkg::*;
();
  logic SYS_CLK = 0, RSTN = 0, HSEL = 0, HWRITE = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, q;
  logic [1:0] HTRANS = 0, DRIVE_NUMBER = 2;
  logic [2:0] HSIZE = 3'h2, DMA_REQ_OUT, DMA_REQ_OE;
  logic STEP_PULSE_N = 0, DRIVE_SELECT_0_N = 0, DRIVE_SELECT_1_N = 0;
  logic DISK_CHANGED_IN_N = 0, WRITE_PROTECT_IN_N = 0;
  logic DENSITY_SELECT = 0, RATE0 = 0, RATE1 = 0;
  logic FLOPPY_DMA_REQ = 1, PARALLEL_DMA_REQ = 1;
  logic FLOPPY_IRQ = 1, PARALLEL_IRQ = 1, HREADYOUT, HRESP;
  logic FLOPPY_DISK_CHANGED_N, FLOPPY_WRITE_PROTECT_N;
  logic DENSITY_OUT_0, DENSITY_OUT_1, CHIP_SELECT_N, HOST_IO_VALID;
  logic GAME_PORT_SELECT, FLOPPY_SELECT, PARALLEL_SELECT;
  logic SERIAL_ONE_SELECT, SERIAL_TWO_SELECT;
  logic [10:0] HOST_ADDR;
  logic [7:0] IRQ_OUT, IRQ_OE, e;
  logic [7:0] ri [9] = '{8'h17, 8'h1E, 8'h1F, 8'h20, 8'h23, 8'h24, 8'h25,
    8'h26, 8'h27};
  logic [7:0] rv [9] = '{8'h03, 8'h80, 8'h00, 8'h3C, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  int fail_count = 0, compares = 0;
  wire HREADY = HREADYOUT;

  superio_resource_config_bank i_dut (
    .SYS_CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .HOST_ADDR, .CHIP_SELECT_N,
    .HOST_IO_VALID, .DISK_CHANGED_IN_N, .WRITE_PROTECT_IN_N, .STEP_PULSE_N,
    .DRIVE_SELECT_0_N, .DRIVE_SELECT_1_N, .DRIVE_NUMBER, .DENSITY_SELECT,
    .RATE0, .RATE1, .FLOPPY_DMA_REQ, .PARALLEL_DMA_REQ, .FLOPPY_IRQ,
    .PARALLEL_IRQ, .FLOPPY_DISK_CHANGED_N, .FLOPPY_WRITE_PROTECT_N,
    .DENSITY_OUT_0, .DENSITY_OUT_1, .GAME_PORT_SELECT, .FLOPPY_SELECT,
    .PARALLEL_SELECT, .SERIAL_ONE_SELECT, .SERIAL_TWO_SELECT, .DMA_REQ_OUT,
    .DMA_REQ_OE, .IRQ_OUT, .IRQ_OE
  );
  isa_host_model i_host (.clk(SYS_CLK), .host_addr(HOST_ADDR),
    .cs_n(CHIP_SELECT_N), .io_valid(HOST_IO_VALID));

  initial
    forever #10 SYS_CLK = ~SYS_CLK;

  task automatic finish_test();
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic hold();
    int n;
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    hold();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    hold();
    q = HRDATA;
  endtask
  task automatic cw(input logic [7:0] i, input logic [7:0] v);
    bus(ADDR_INDEX, 1'b1, {24'h0, i});
    bus(ADDR_DATA, 1'b1, {24'h0, v});
  endtask
  task automatic crc(input logic [7:0] i, input logic [7:0] x);
    bus(ADDR_INDEX, 1'b1, {24'h0, i});
    bus(ADDR_DATA, 1'b0, 32'h0);
    chk(q, {24'h0, x});
    chk({31'h0, HRESP}, 32'h0);
  endtask
  task automatic settle();
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic pins(input logic [4:0] v);
    @(posedge SYS_CLK);
    {STEP_PULSE_N, DRIVE_SELECT_0_N, DRIVE_SELECT_1_N, DISK_CHANGED_IN_N,
      WRITE_PROTECT_IN_N} <= v;
    settle();
  endtask
  task automatic io(input logic [10:0] a, input logic c, input logic [4:0] x);
    i_host.cycle(a, c);
    #1;
    chk({27'h0, GAME_PORT_SELECT, FLOPPY_SELECT, PARALLEL_SELECT,
      SERIAL_ONE_SELECT, SERIAL_TWO_SELECT}, {27'h0, x});
  endtask

  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    // index and data refused outside the configuration state
    bus(ADDR_CTRL, 1'b1, 32'h1);
    bus(ADDR_INDEX, 1'b1, 32'h1E);
    bus(ADDR_CTRL, 1'b1, 32'h0);
    bus(ADDR_INDEX, 1'b1, 32'h17);
    bus(ADDR_DATA, 1'b1, 32'h0);
    bus(ADDR_DATA, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(ADDR_INDEX, 1'b0, 32'h0);
    chk(q, 32'h1E);
    bus(ADDR_CTRL, 1'b1, 32'h1);
    bus(8'h10, 1'b0, 32'h0);
    chk(q, 32'h0);
    foreach (ri[k]) crc(ri[k], rv[k]);
    for (int i = 8'h18; i <= 8'h22; i++)
      if (i < 8'h1E || i > 8'h20)
      begin
        cw(i[7:0], 8'hFF);
        crc(i[7:0], 8'h00);
      end
    cw(IDX_DRIVE_STATUS_OVERRIDE, 8'h00);
    crc(IDX_DRIVE_STATUS_OVERRIDE, 8'h03);
    pins(5'b01000);
    chk({30'h0, FLOPPY_DISK_CHANGED_N, FLOPPY_WRITE_PROTECT_N}, 32'h2);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    chk({31'h0, q[7]}, 32'h1);
    pins(5'b11000);
    crc(IDX_DRIVE_STATUS_OVERRIDE, 8'h02);
    chk({30'h0, FLOPPY_DISK_CHANGED_N, FLOPPY_WRITE_PROTECT_N}, 32'h0);
    pins(5'b01000);
    cw(IDX_DRIVE_STATUS_OVERRIDE, 8'h04);
    settle();
    chk({30'h0, FLOPPY_DISK_CHANGED_N, FLOPPY_WRITE_PROTECT_N}, 32'h1);
    crc(IDX_DRIVE_STATUS_OVERRIDE, 8'h06);
    cw(IDX_DRIVE_STATUS_OVERRIDE, 8'h00);
    crc(IDX_DRIVE_STATUS_OVERRIDE, 8'h02);
    pins(5'b00111);
    chk({30'h0, FLOPPY_DISK_CHANGED_N, FLOPPY_WRITE_PROTECT_N}, 32'h3);
    pins(5'b00000);
    for (int t = 0; t < 8; t++)
    begin
      cw(IDX_DRIVE_TYPE_MAP, 8'(t[1:0]) << (2 * t[2:1]));
      DRIVE_NUMBER <= t[2:1];
      {DENSITY_SELECT, RATE1, RATE0} <= t[2] ? 3'b001 : 3'b110;
      settle();
      case (t[1:0])
        2'h0: e = {6'h0, DENSITY_SELECT, RATE0};
        2'h1: e = {6'h0, RATE1, RATE0};
        2'h2: e = {6'h0, ~DENSITY_SELECT, RATE0};
        default: e = {6'h0, RATE0, RATE1};
      endcase
      chk({30'h0, DENSITY_OUT_0, DENSITY_OUT_1}, {24'h0, e});
    end
    cw(IDX_GAME_SELECT_BASE, 8'h4D);
    cw(IDX_FLOPPY_BASE, 8'hFF);
    cw(IDX_PARALLEL_BASE, 8'hDE);
    cw(IDX_SERIAL_ONE_BASE, 8'hFF);
    cw(IDX_SERIAL_TWO_BASE, 8'h5F);
    crc(IDX_FLOPPY_BASE, 8'hFC);
    crc(IDX_SERIAL_ONE_BASE, 8'hFE);
    crc(IDX_SERIAL_TWO_BASE, 8'h5E);
    io(11'h131, 1'b0, 5'h10);
    io(11'h130, 1'b0, 5'h00);
    io(11'h531, 1'b0, 5'h00);
    io(11'h131, 1'b1, 5'h00);
    io(11'h3F5, 1'b0, 5'h08);
    io(11'h3FA, 1'b0, 5'h02);
    io(11'h2F5, 1'b0, 5'h00);
    io(11'h37B, 1'b0, 5'h04);
    io(11'h37C, 1'b0, 5'h00);
    io(11'h77B, 1'b0, 5'h00);
    io(11'h17F, 1'b0, 5'h01);
    cw(IDX_GAME_SELECT_BASE, 8'h4F);
    io(11'h13E, 1'b0, 5'h10);
    cw(IDX_GAME_SELECT_BASE, 8'h4E);
    io(11'h137, 1'b0, 5'h10);
    io(11'h138, 1'b0, 5'h00);
    cw(IDX_GAME_SELECT_BASE, 8'h4C);
    io(11'h131, 1'b0, 5'h00);
    cw(IDX_GAME_SELECT_BASE, 8'h4D);
    bus(ADDR_CTRL, 1'b1, 32'h9);
    io(11'h131, 1'b0, 5'h00);
    bus(ADDR_CTRL, 1'b1, 32'h3);
    io(11'h37C, 1'b0, 5'h04);
    bus(ADDR_CTRL, 1'b1, 32'h5);
    io(11'h77B, 1'b0, 5'h04);
    cw(IDX_SERIAL_ONE_BASE, 8'h3E);
    io(11'h0F8, 1'b0, 5'h00);
    for (int c = 0; c < 16; c++)
    begin
      cw(IDX_IRQ_SELECT, {c[3:0], 4'h0});
      cw(IDX_DMA_SELECT, {c[3:0], 4'h0});
      settle();
      e = (c >= 1 && c <= 6) ? 8'h1 << (c - 1) : (c == 8) ? 8'h80 : 8'h0;
      chk({16'h0, IRQ_OE, IRQ_OUT}, {16'h0, e, e});
      e = (c >= 1 && c <= 3) ? 8'h1 << (c - 1) : 8'h0;
      chk({26'h0, DMA_REQ_OE, DMA_REQ_OUT}, {26'h0, e[2:0], e[2:0]});
    end
    PARALLEL_DMA_REQ <= 1'b0;
    cw(IDX_DMA_SELECT, 8'h21);
    cw(IDX_IRQ_SELECT, 8'h03);
    settle();
    chk({26'h0, DMA_REQ_OE, DMA_REQ_OUT}, 32'h1A);
    chk({24'h0, IRQ_OE}, 32'h04);
    finish_test();
  end
endmodule // test_superio_resource_config_bank
